/* File: dv/dpi_i2c_mst.sv */
// Behavioural serial bus master that drives the slave port under test.
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Master model: open-drain SDA, push-pull SCL, bit timing in quarters.
// ----------------------------------------------------------------------
module dpi_i2c_mst (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_low,
    output logic res_valid,
    output logic [8:0] res_data
);
    // A quarter bit of ten clocks keeps every level far above the filter.
    localparam int Q = 10;

    // The bus idles with SDA released to the pull-up and SCL driven high.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        res_valid = 1'b0;
        res_data = 9'h000;
    end

    task automatic qw(input int n);
        repeat (n * Q) @(negedge clk);
    endtask

    // SDA falls while SCL is high; works as a repeated start as well.
    task automatic start();
        sda_low = 1'b0;
        qw(1);
        scl = 1'b1;
        qw(2);
        sda_low = 1'b1;
        qw(2);
        scl = 1'b0;
        qw(1);
    endtask

    // SDA rises while SCL is high.
    task automatic stop();
        sda_low = 1'b1;
        qw(1);
        scl = 1'b1;
        qw(1);
        sda_low = 1'b0;
        qw(2);
    endtask

    // One clocked bit; a one releases SDA so the slave may pull it low.
    task automatic tbit(input logic b, output logic s);
        sda_low = ~b;
        qw(1);
        scl = 1'b1;
        qw(1);
        s = sda_in;
        qw(1);
        scl = 1'b0;
        qw(1);
    endtask

    // Eight bits then the acknowledge slot; the sampled word is reported.
    task automatic xfer(input logic [7:0] tx, input logic ack, input bit rep);
        logic [8:0] w;
        logic s;
        for (int i = 7; i >= 0; i--) begin
            tbit(tx[i], s);
            w[i+1] = s;
        end
        tbit(ack, s);
        w[0] = s;
        if (rep) begin
            res_data = w;
            res_valid = 1'b1;
            @(negedge clk);
            res_valid = 1'b0;
        end
    endtask

    // A truncated byte, used to break a transfer before its ack slot.
    task automatic part(input int n, input logic [7:0] tx);
        logic s;
        for (int i = 0; i < n; i++) begin
            tbit(tx[7-i], s);
        end
    endtask
endmodule

/* File: dv/dpi_i2c_slave_port_tb.sv */
// Self-checking testbench for the potentiometer serial slave port.
`timescale 1ns/100ps
`include "dpi_defines.svh"

module dpi_i2c_slave_port_tb;
    logic ref_clk;
    logic rstn;
    logic load_hold;
    logic sda_o;
    logic sda_oe;
    logic [6:0] wiper;
    logic bus_active;
    logic scl;
    logic sda_low;
    logic res_valid;
    logic [8:0] res_data;
    logic sda_bus;
    logic [8:0] exp_q[$];
    logic [7:0] d;
    logic [6:0] last;
    logic [6:0] a;
    logic [31:0] seed;
    int n_mismatch;
    int total_checks;
    int cyc;

    // --------------------------------------------------------------
    // Clock, wired-AND bus with pull-up, design and partner.
    // --------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    assign sda_bus = ~(sda_low | (sda_oe & ~sda_o));

    dpi_i2c_slave i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_bus),
        .sda_o(sda_o), .sda_oe(sda_oe), .load_hold(load_hold),
        .wiper(wiper), .bus_active(bus_active)
    );

    dpi_i2c_mst i_mst (
        .clk(ref_clk), .sda_in(sda_bus), .scl(scl), .sda_low(sda_low),
        .res_valid(res_valid), .res_data(res_data)
    );

    // --------------------------------------------------------------
    // Checking and closing helpers.
    // --------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [8:0] s,
                       input logic [8:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Notes the bus word expected back, then runs the byte on the bus.
    task automatic xb(input logic [7:0] tx, input logic ack,
                      input logic [8:0] e);
        exp_q.push_back(e);
        i_mst.xfer(tx, ack, 1'b1);
    endtask

    task automatic wiper_is(input logic [6:0] e);
        chk("wiper", {2'b00, wiper}, {2'b00, e});
    endtask

    // Each reported bus word is matched against the oldest note.
    always @(posedge ref_clk) begin
        if (res_valid === 1'b1) begin
            chk("bus word", res_data, exp_q.pop_front());
        end
    end

    // A hang is cut short well above the length of the sequence.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // --------------------------------------------------------------
    // Main sequence.
    // --------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        load_hold = 1'b0;
        seed = 32'hd67a0a10;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (12) @(negedge ref_clk);
        wiper_is(`DPI_WIPER_RST);
        // Two-byte write with the ignored top bit set; each byte lands.
        i_mst.start();
        xb({`DPI_SLAVE_ADDR, 1'b0}, 1'b1, {`DPI_SLAVE_ADDR, 2'b00});
        for (int i = 0; i < 2; i++) begin
            d = rnd() | 8'h80;
            xb(d, 1'b1, {d, 1'b0});
            wiper_is(d[6:0]);
        end
        last = d[6:0];
        i_mst.stop();
        repeat (8) @(negedge ref_clk);
        chk("idle", {8'h00, bus_active}, 9'h000);
        // Two-byte read: master acks the first and refuses the last.
        i_mst.start();
        xb({`DPI_SLAVE_ADDR, 1'b1}, 1'b1, {`DPI_SLAVE_ADDR, 2'b10});
        xb(8'hff, 1'b0, {1'b0, last, 1'b0});
        xb(8'hff, 1'b1, {1'b0, last, 1'b1});
        i_mst.stop();
        // General call and a foreign address are refused, data ignored.
        for (int k = 0; k < 2; k++) begin
            a = (k == 0) ? `DPI_GCALL_ADDR : (rnd() | 7'h40);
            d = rnd();
            i_mst.start();
            xb({a, 1'b0}, 1'b1, {a, 2'b01});
            xb(d, 1'b1, {d, 1'b1});
            i_mst.stop();
            wiper_is(last);
        end
        // A partial byte cut by a stop, then by a repeated start.
        for (int k = 0; k < 2; k++) begin
            i_mst.start();
            xb({`DPI_SLAVE_ADDR, 1'b0}, 1'b1, {`DPI_SLAVE_ADDR, 2'b00});
            i_mst.part(4 + k, rnd());
            if (k == 1) begin
                i_mst.start();
            end
            i_mst.stop();
            wiper_is(last);
        end
        // Recovery mid-write, then while the slave drives a low read bit.
        for (int k = 0; k < 2; k++) begin
            i_mst.start();
            xb({`DPI_SLAVE_ADDR, k[0]}, 1'b1,
               {`DPI_SLAVE_ADDR, k[0], 1'b0});
            if (k == 0) begin
                i_mst.part(3, rnd());
            end
            i_mst.start();
            i_mst.xfer(8'hff, 1'b1, 1'b0);
            i_mst.start();
            i_mst.stop();
            wiper_is(last);
        end
        // Stall the buffer: eight bytes fit, the ninth is refused.
        load_hold = 1'b1;
        i_mst.start();
        xb({`DPI_SLAVE_ADDR, 1'b0}, 1'b1, {`DPI_SLAVE_ADDR, 2'b00});
        for (int i = 0; i < 9; i++) begin
            d = rnd();
            xb(d, 1'b1, {d, (i == 8)});
            if (i < 8) begin
                a = d[6:0];
            end
        end
        i_mst.stop();
        wiper_is(last);
        load_hold = 1'b0;
        repeat (30) @(negedge ref_clk);
        wiper_is(a);
        repeat (20) @(negedge ref_clk);
        end_sim();
    end
endmodule

/* File: rtl/dpi_defines.svh */
// Constants for the digital potentiometer serial slave port.
`ifndef DPI_DEFINES_SVH
`define DPI_DEFINES_SVH
`define DPI_SLAVE_ADDR 7'h2f
`define DPI_GCALL_ADDR 7'h00
`define DPI_WIPER_RST 7'h3f
`define DPI_BYTE_BITS 4'h8
`define DPI_CNT_ZERO 4'h0
`define DPI_CNT_ONE 4'h1
`define DPI_FIFO_WIDTH 7
`define DPI_FIFO_DEPTH 8
`endif

/* File: rtl/dpi_i2c_slave.sv */
// Serial slave port of a 7-bit volatile digital potentiometer.
`timescale 1ns/100ps
`include "dpi_defines.svh"
// --------------------------------------------------------------------
// Small FIFO with valid and ready on both sides.
// --------------------------------------------------------------------
module dpi_fifo #(
    parameter int WIDTH = `DPI_FIFO_WIDTH,
    parameter int DEPTH = `DPI_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q, rd_ptr_q;
    logic [AW:0] count_q;
    logic push, pop;
    // Full and empty come straight from the occupancy count.
    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];
    // Storage array; written only, never reset.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end
    // Pointers wrap through the power-of-two depth.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
            end
            if (push && !pop) begin
                count_q <= count_q + (AW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end
endmodule
// --------------------------------------------------------------------
// Slave port top level.
// --------------------------------------------------------------------
module dpi_i2c_slave
    import dpi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic load_hold,
    output logic [6:0] wiper,
    output logic bus_active
);
    logic rst_meta_q, rst_n_q;
    logic [2:0] scl_sync_q, sda_sync_q;
    logic scl_q, sda_q, scl_prev_q, sda_prev_q;
    logic scl_rise, scl_fall, start_det, stop_det, byte_done;
    dpi_state_type state_q;
    logic [3:0] cnt_q;
    logic [7:0] rx_q, tx_q;
    logic rw_q, drv_q, push_q;
    logic [6:0] push_data_q, fifo_out_data, wiper_q;
    logic fifo_in_ready, fifo_out_valid, pop;
    // ----------------------------------------------------------------
    // Reset release and pin synchronisers.
    // ----------------------------------------------------------------
    // Reset asserts at once and releases two edges later.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end
    // Change taken once stages two and three agree; spikes rejected.
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_i};
            sda_sync_q <= {sda_sync_q[1:0], sda_i};
            if (scl_sync_q[1] == scl_sync_q[2]) begin
                scl_q <= scl_sync_q[2];
            end
            if (sda_sync_q[1] == sda_sync_q[2]) begin
                sda_q <= sda_sync_q[2];
            end
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end
    // Bus events from the filtered levels.
    assign scl_rise = scl_q && !scl_prev_q;
    assign scl_fall = !scl_q && scl_prev_q;
    assign start_det = scl_q && scl_prev_q && !sda_q && sda_prev_q;
    assign stop_det = scl_q && scl_prev_q && sda_q && !sda_prev_q;
    assign byte_done = scl_fall && (cnt_q == `DPI_BYTE_BITS);
    // ----------------------------------------------------------------
    // Protocol state machine.
    // ----------------------------------------------------------------
    // Start and stop win over every state, so a stray one aborts.
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= DPI_IDLE;
            cnt_q <= `DPI_CNT_ZERO;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            drv_q <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= 7'h00;
        end else begin
            push_q <= 1'b0;
            if (start_det) begin
                // A start always re-arms address decode.
                state_q <= DPI_ADDR;
                cnt_q <= `DPI_CNT_ZERO;
                drv_q <= 1'b0;
            end else if (stop_det) begin
                state_q <= DPI_IDLE;
                drv_q <= 1'b0;
            end else begin
                case (state_q)
                    DPI_IDLE: begin
                        drv_q <= 1'b0;
                    end
                    DPI_ADDR: begin
                        if (scl_rise) begin
                            rx_q <= {rx_q[6:0], sda_q};
                            cnt_q <= cnt_q + `DPI_CNT_ONE;
                        end else if (byte_done) begin
                            // General call goes silent.
                            if (rx_q[7:1] == `DPI_SLAVE_ADDR) begin
                                drv_q <= 1'b1;
                                rw_q <= rx_q[0];
                                state_q <= DPI_ADDR_ACK;
                            end else begin
                                state_q <= DPI_IDLE;
                            end
                        end
                    end
                    DPI_ADDR_ACK: begin
                        if (scl_fall) begin
                            cnt_q <= `DPI_CNT_ZERO;
                            if (rw_q) begin
                                // Byte is ready at once, no stretch.
                                tx_q <= {1'b0, wiper_q};
                                drv_q <= 1'b1;
                                state_q <= DPI_RD_DATA;
                            end else begin
                                drv_q <= 1'b0;
                                state_q <= DPI_WR_DATA;
                            end
                        end
                    end
                    DPI_WR_DATA: begin
                        if (scl_rise) begin
                            rx_q <= {rx_q[6:0], sda_q};
                            cnt_q <= cnt_q + `DPI_CNT_ONE;
                        end else if (byte_done) begin
                            // Full buffer: NACK rather than a stretch.
                            if (fifo_in_ready) begin
                                push_q <= 1'b1;
                                push_data_q <= rx_q[6:0];
                                drv_q <= 1'b1;
                                state_q <= DPI_WR_ACK;
                            end else begin
                                state_q <= DPI_IDLE;
                            end
                        end
                    end
                    DPI_WR_ACK: begin
                        if (scl_fall) begin
                            drv_q <= 1'b0;
                            cnt_q <= `DPI_CNT_ZERO;
                            state_q <= DPI_WR_DATA;
                        end
                    end
                    DPI_RD_DATA: begin
                        if (scl_rise) begin
                            cnt_q <= cnt_q + `DPI_CNT_ONE;
                        end else if (byte_done) begin
                            drv_q <= 1'b0;
                            state_q <= DPI_RD_ACK;
                        end else if (scl_fall) begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            drv_q <= !tx_q[6];
                        end
                    end
                    DPI_RD_ACK: begin
                        if (scl_rise && sda_q) begin
                            state_q <= DPI_RD_END;
                        end else if (scl_fall) begin
                            cnt_q <= `DPI_CNT_ZERO;
                            tx_q <= {1'b0, wiper_q};
                            drv_q <= 1'b1;
                            state_q <= DPI_RD_DATA;
                        end
                    end
                    DPI_RD_END: begin
                        // Only stop or repeated start may follow; else
                        // a collision.
                        if ((scl_rise && !sda_q) || scl_fall) begin
                            state_q <= DPI_IDLE;
                        end
                    end
                    default: begin
                        state_q <= DPI_IDLE;
                        drv_q <= 1'b0;
                    end
                endcase
            end
        end
    end
    // ----------------------------------------------------------------
    // Wiper path through the buffer.
    // ----------------------------------------------------------------
    // Bytes queue here; the wiper loads from the head unless held.
    dpi_fifo #(
        .WIDTH(`DPI_FIFO_WIDTH),
        .DEPTH(`DPI_FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n_q),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(push_data_q),
        .out_valid(fifo_out_valid),
        .out_ready(!load_hold),
        .out_data(fifo_out_data)
    );
    assign pop = fifo_out_valid && !load_hold;
    // Wiper comes up at mid-scale and changes only from the buffer.
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wiper_q <= `DPI_WIPER_RST;
        end else if (pop) begin
            wiper_q <= fifo_out_data;
        end
    end
    // Open drain: SDA only ever pulled low; SCL is never driven.
    assign sda_o = 1'b0;
    assign sda_oe = drv_q;
    assign wiper = wiper_q;
    assign bus_active = (state_q != DPI_IDLE);
    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n_q);
    property p_stop_idle;
        stop_det && !start_det |=> state_q == DPI_IDLE && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("stop did not return to idle");
    property p_start_addr;
        start_det |=> state_q == DPI_ADDR && cnt_q == `DPI_CNT_ZERO;
    endproperty
    a_start_addr: assert property (p_start_addr)
        else $error("start did not restart address decode");
    property p_addr_ack;
        state_q == DPI_ADDR && byte_done && !start_det && !stop_det
            && rx_q[7:1] == `DPI_SLAVE_ADDR
            |=> sda_oe && state_q == DPI_ADDR_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("matching address not acknowledged");
    property p_gcall;
        state_q == DPI_ADDR && byte_done && !start_det && !stop_det
            && rx_q[7:1] == `DPI_GCALL_ADDR
            |=> !sda_oe && state_q == DPI_IDLE;
    endproperty
    a_gcall: assert property (p_gcall)
        else $error("general call was acknowledged");
    property p_push_ack;
        push_q |-> sda_oe && state_q == DPI_WR_ACK;
    endproperty
    a_push_ack: assert property (p_push_ack)
        else $error("byte committed outside its ack slot");
    property p_partial;
        state_q == DPI_WR_DATA && (start_det || stop_det) |=> !push_q [*2];
    endproperty
    a_partial: assert property (p_partial)
        else $error("partial byte was committed");
    property p_wiper_src;
        !$stable(wiper_q) |-> $past(pop);
    endproperty
    a_wiper_src: assert property (p_wiper_src)
        else $error("wiper changed without a committed byte");
    property p_rd_release;
        state_q == DPI_RD_ACK |-> !sda_oe;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("SDA driven in read ack slot");
    property p_msb_zero;
        state_q == DPI_ADDR_ACK && scl_fall && rw_q
            && !start_det && !stop_det |=> sda_oe;
    endproperty
    a_msb_zero: assert property (p_msb_zero)
        else $error("read MSB not driven as zero");
    property p_nack_reset;
        state_q == DPI_RD_ACK && scl_rise && sda_q
            && !start_det && !stop_det |=> state_q == DPI_RD_END;
    endproperty
    a_nack_reset: assert property (p_nack_reset)
        else $error("master NACK did not end the read");
    property p_collision;
        state_q == DPI_RD_END && scl_fall |=> state_q == DPI_IDLE;
    endproperty
    a_collision: assert property (p_collision)
        else $error("collision did not reset the port");
    c_write: cover property (push_q ##[1:1000] pop);
    c_read: cover property (state_q == DPI_RD_ACK ##1 state_q == DPI_RD_END);
    c_gcall: cover property (state_q == DPI_ADDR && byte_done
        && rx_q[7:1] == `DPI_GCALL_ADDR);
    c_full: cover property (state_q == DPI_WR_DATA && byte_done
        && !fifo_in_ready);
endmodule

/* File: rtl/dpi_pkg.sv */
// Types shared by the digital potentiometer serial slave port.
package dpi_pkg;
    typedef enum logic [2:0] {
        DPI_IDLE = 3'b000,
        DPI_ADDR = 3'b001,
        DPI_ADDR_ACK = 3'b010,
        DPI_WR_DATA = 3'b011,
        DPI_WR_ACK = 3'b100,
        DPI_RD_DATA = 3'b101,
        DPI_RD_ACK = 3'b110,
        DPI_RD_END = 3'b111
    } dpi_state_type;
endpackage
